// ===== rtl/mdmctl_master.sv
// Station management controller driving the MDC and MDIO pins
// Notes on behaviour
// - The controller alone makes the management clock; the device never drives it.
// - Each data bit is captured on the rising management clock edge.
// - A preamble is thirty-two ones, one per management clock.
// - After the preamble comes start pattern 0 then 1.
// - Opcode 10 reads, 01 writes; it sets transfer direction.
// - Five-bit PHY then five-bit register address, MSB first.
// - Write turnaround is one then zero, driven by the controller.
// - Read turnaround: line released first bit, device drives zero second.
// - Sixteen data bits: controller supplies on write, device on read.
// - Every frame ends with at least one undriven idle bit.
// - First transaction after reset carries full preamble; later may omit.
`timescale 1ns/10ps
module mdmctl_master #(
   parameter int HALF_CYCLES = mdmctl_pkg::MDC_HALF_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic [4:0] cmd_phy,
   input wire logic [4:0] cmd_reg,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_no_pre,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic rsp_ta_err,
   output logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe
);
   // ----------------------------------------
   // Clock divider
   // ----------------------------------------
   mdmctl_tick_if tk ();
   mdmctl_clkgen #(.HALF_CYCLES(HALF_CYCLES)) u_clkgen (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tk(tk)
   );
   mdmctl_pkg::mdmctl_state_t state_q;
   logic [5:0] cnt_q;
   logic [13:0] hdr_q;
   logic [15:0] wsh_q;
   logic [15:0] rsh_q;
   logic is_read_q;
   logic pre_done_q;
   logic mdio_s1_q;
   logic mdio_s2_q;
   logic mdc_q;
   logic ta_bad_q;
   logic take;
   assign take = (state_q == mdmctl_pkg::MDMCTL_IDLE) && cmd_valid;
   assign tk.run = (state_q != mdmctl_pkg::MDMCTL_IDLE);
   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
      end else begin
         mdio_s1_q <= mdio_i;
         mdio_s2_q <= mdio_s1_q;
      end
   end
   // Management clock output, registered; no other party drives it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= tk.mdc;
      end
   end
   assign mdc = mdc_q;
   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   // Bits change on falling edges so the device samples them mid-bit on rising edges
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= mdmctl_pkg::MDMCTL_IDLE;
         cnt_q <= 6'h00;
      end else if (take) begin
         // Suppression only honoured after a first full-preamble frame
         if (cmd_no_pre && pre_done_q) begin
            state_q <= mdmctl_pkg::MDMCTL_HDR;
            cnt_q <= 6'(mdmctl_pkg::HDR_BITS - 1);
         end else begin
            state_q <= mdmctl_pkg::MDMCTL_PRE;
            cnt_q <= 6'(mdmctl_pkg::PREAMBLE_BITS - 1);
         end
      end else if (tk.fall) begin
         unique case (state_q)
            mdmctl_pkg::MDMCTL_IDLE: begin
               cnt_q <= 6'h00;
            end
            mdmctl_pkg::MDMCTL_PRE: begin
               if (cnt_q == 6'h00) begin
                  state_q <= mdmctl_pkg::MDMCTL_HDR;
                  cnt_q <= 6'(mdmctl_pkg::HDR_BITS - 1);
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            mdmctl_pkg::MDMCTL_HDR: begin
               if (cnt_q == 6'h00) begin
                  state_q <= mdmctl_pkg::MDMCTL_TA;
                  cnt_q <= 6'h01;
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            mdmctl_pkg::MDMCTL_TA: begin
               if (cnt_q == 6'h00) begin
                  state_q <= mdmctl_pkg::MDMCTL_DATA;
                  cnt_q <= 6'(mdmctl_pkg::DATA_BITS - 1);
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            mdmctl_pkg::MDMCTL_DATA: begin
               if (cnt_q == 6'h00) begin
                  state_q <= mdmctl_pkg::MDMCTL_END;
                  cnt_q <= 6'(mdmctl_pkg::IDLE_BITS - 1);
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            mdmctl_pkg::MDMCTL_END: begin
               if (cnt_q == 6'h00) begin
                  state_q <= mdmctl_pkg::MDMCTL_IDLE;
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_done_q <= 1'b0;
      end else if (state_q == mdmctl_pkg::MDMCTL_HDR) begin
         pre_done_q <= 1'b1;
      end
   end
   // ----------------------------------------
   // Transmit shifters
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hdr_q <= 14'h0000;
         wsh_q <= 16'h0000;
         is_read_q <= 1'b0;
      end else if (take) begin
         // Start, opcode, PHY address, register address, all MSB first
         hdr_q <= {mdmctl_pkg::START_CODE,
            cmd_read ? mdmctl_pkg::OP_READ : mdmctl_pkg::OP_WRITE,
            cmd_phy, cmd_reg};
         wsh_q <= cmd_wdata;
         is_read_q <= cmd_read;
      end else if (tk.fall) begin
         if (state_q == mdmctl_pkg::MDMCTL_HDR && cnt_q != 6'h00) begin
            hdr_q <= {hdr_q[12:0], 1'b0};
         end
         if (state_q == mdmctl_pkg::MDMCTL_DATA && cnt_q != 6'h00) begin
            wsh_q <= {wsh_q[14:0], 1'b0};
         end
      end
   end
   // Pin drive follows state; released during read turnaround, read data and idle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdio_o <= 1'b1;
         mdio_oe <= 1'b0;
      end else begin
         unique case (state_q)
            mdmctl_pkg::MDMCTL_PRE: begin
               mdio_o <= 1'b1;
               mdio_oe <= 1'b1;
            end
            mdmctl_pkg::MDMCTL_HDR: begin
               mdio_o <= hdr_q[13];
               mdio_oe <= 1'b1;
            end
            mdmctl_pkg::MDMCTL_TA: begin
               mdio_o <= mdmctl_pkg::TA_WRITE[cnt_q[0]];
               mdio_oe <= !is_read_q;
            end
            mdmctl_pkg::MDMCTL_DATA: begin
               mdio_o <= wsh_q[15];
               mdio_oe <= !is_read_q;
            end
            mdmctl_pkg::MDMCTL_IDLE, mdmctl_pkg::MDMCTL_END: begin
               mdio_o <= 1'b1;
               mdio_oe <= 1'b0;
            end
         endcase
      end
   end
   // ----------------------------------------
   // Receive path
   // ----------------------------------------
   // Sampled on the rising edge; a line left high by the pull-up reads as ones,
   // so an absent device shows as a turnaround error with data 16'hFFFF
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsh_q <= 16'h0000;
         ta_bad_q <= 1'b0;
      end else if (take) begin
         ta_bad_q <= 1'b0;
      end else if (tk.rise && is_read_q) begin
         if (state_q == mdmctl_pkg::MDMCTL_TA && cnt_q == 6'h00) begin
            ta_bad_q <= mdio_s2_q;
         end
         if (state_q == mdmctl_pkg::MDMCTL_DATA) begin
            rsh_q <= {rsh_q[14:0], mdio_s2_q};
         end
      end
   end
   // ----------------------------------------
   // Command handshake and result
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= (state_q == mdmctl_pkg::MDMCTL_IDLE) && !take;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         rsp_ta_err <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (tk.fall && state_q == mdmctl_pkg::MDMCTL_END && cnt_q == 6'h00) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= is_read_q ? rsh_q : 16'h0000;
            rsp_ta_err <= is_read_q && ta_bad_q;
         end
      end
   end
endmodule : mdmctl_master

// ===== include/mdmctl_pkg.sv
// Package of constants and types for the MDIO management controller
package mdmctl_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int PREAMBLE_BITS = 32;
   localparam logic [1:0] START_CODE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;
   localparam int ADDR_BITS = 5;
   localparam int DATA_BITS = 16;
   localparam int HDR_BITS = 14;
   localparam int IDLE_BITS = 1;
   // ----------------------------------------
   // Device register map
   // ----------------------------------------
   localparam logic [4:0] BASIC_STATUS_REG = 5'h01;
   localparam logic [4:0] MANAGEMENT_CONTROL_REG = 5'h14;
   localparam int STATUS_PRE_SUPP_BIT = 6;
   localparam int CONTROL_PRE_SUPP_BIT = 1;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int REF_CLK_PERIOD_PS = 4000;
   localparam int MDC_HALF_MIN_NS = 160;
   localparam int MDC_PERIOD_MIN_NS = 400;
   localparam int MDC_HALF_CYCLES_RAW = (MDC_HALF_MIN_NS * 1000 + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
   localparam int MDC_PER_HALF_CYCLES = (MDC_PERIOD_MIN_NS * 1000 + 2 * REF_CLK_PERIOD_PS - 1)
      / (2 * REF_CLK_PERIOD_PS);
   localparam int MDC_HALF_CYCLES = (MDC_HALF_CYCLES_RAW > MDC_PER_HALF_CYCLES) ?
      MDC_HALF_CYCLES_RAW : MDC_PER_HALF_CYCLES;
   typedef enum logic [2:0] {
      MDMCTL_IDLE, MDMCTL_PRE, MDMCTL_HDR, MDMCTL_TA, MDMCTL_DATA, MDMCTL_END
   } mdmctl_state_t;
endpackage : mdmctl_pkg

// ===== include/mdmctl_tick_if.sv
// Interface carrying the management clock phase strobes
`timescale 1ns/10ps
interface mdmctl_tick_if;
   logic run;
   logic rise;
   logic fall;
   logic mdc;
   modport gen (input run, output rise, output fall, output mdc);
   modport use_p (output run, input rise, input fall, input mdc);
endinterface : mdmctl_tick_if

// ===== rtl/mdmctl_clkgen.sv
// Divider that makes the management clock and its edge strobes
`timescale 1ns/10ps
module mdmctl_clkgen #(
   parameter int HALF_CYCLES = mdmctl_pkg::MDC_HALF_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   mdmctl_tick_if.gen tk
);
   logic [7:0] cnt_q;
   logic mdc_q;
   logic wrap;
   assign wrap = (cnt_q == 8'(HALF_CYCLES - 1));
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else if (!tk.run || wrap) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // Clock parks low between frames so each frame begins with a full low half
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_q <= 1'b0;
      end else if (tk.run && wrap) begin
         mdc_q <= ~mdc_q;
      end else if (!tk.run) begin
         mdc_q <= 1'b0;
      end
   end
   assign tk.rise = tk.run && wrap && !mdc_q;
   assign tk.fall = tk.run && wrap && mdc_q;
   assign tk.mdc = mdc_q;
endmodule : mdmctl_clkgen

// ===== verification/mdmctl_master_asserts.sv
// Port-level checks for the management controller
`timescale 1ns/10ps
module mdmctl_master_asserts #(
   parameter int HALF_CYCLES = mdmctl_pkg::MDC_HALF_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic cmd_read,
   input wire logic cmd_no_pre,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_rdata,
   input wire logic rsp_ta_err,
   input wire logic mdc,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   localparam int PRE = mdmctl_pkg::PREAMBLE_BITS;
   localparam int HDR = mdmctl_pkg::HDR_BITS;
   localparam int DAT = mdmctl_pkg::DATA_BITS;
   logic take;
   logic mdc_q;
   logic rd_q;
   logic np_q;
   logic pre_done_q;
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   logic [7:0] dr_q;
   assign take = cmd_valid && cmd_ready;
   // ----------------------------------------
   // Clock shape and reset history
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_q <= 1'b0;
         hi_q <= 8'h00;
         pre_done_q <= 1'b0;
      end else begin
         mdc_q <= mdc;
         hi_q <= mdc ? hi_q + 8'h01 : 8'h00;
         pre_done_q <= pre_done_q || rsp_valid;
      end
   end
   // ----------------------------------------
   // Per-frame rise counts, split by who owns the line
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         np_q <= 1'b0;
         lo_q <= 8'h00;
         dr_q <= 8'h00;
      end else if (take) begin
         rd_q <= cmd_read;
         np_q <= cmd_no_pre && pre_done_q;
         lo_q <= 8'h00;
         dr_q <= 8'h00;
      end else if (mdc && !mdc_q) begin
         lo_q <= lo_q + {7'h00, !mdio_oe};
         dr_q <= dr_q + {7'h00, mdio_oe};
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_pre_run;
      (mdio_oe && mdio_o) [*8];
   endsequence
   sequence s_back_idle;
      !rsp_valid ##[0:2] cmd_ready;
   endsequence
   a_mdc_parked: assert property (cmd_ready |-> !mdc) else $error("mdc moving while idle");
   a_line_free: assert property (cmd_ready |-> !mdio_oe) else $error("mdio driven while idle");
   a_bits_steady: assert property (mdc |-> $stable(mdio_oe) && (!mdio_oe || $stable(mdio_o)))
      else $error("mdio changed while mdc high");
   a_mdc_high: assert property (!mdc && mdc_q |-> hi_q == HALF_CYCLES) else $error("mdc high time");
   a_pre_ones: assert property (take && !cmd_no_pre |-> ##[1:3] s_pre_run) else $error("no preamble");
   a_first_pre: assert property (take && !pre_done_q |-> ##[1:3] s_pre_run) else $error("first frame");
   a_rsp_pulse: assert property (rsp_valid |=> s_back_idle) else $error("response pulse");
   a_read_release: assert property (rsp_valid && rd_q |-> lo_q == DAT + 3) else $error("read release");
   a_read_hdr: assert property (rsp_valid && rd_q |-> dr_q == (np_q ? 0 : PRE) + HDR)
      else $error("read header length");
   a_write_drive: assert property (rsp_valid && !rd_q |-> lo_q == 1 && dr_q == (np_q ? 0 : PRE) + HDR + 2 + DAT)
      else $error("write frame length");
   a_write_clean: assert property (rsp_valid && !rd_q |-> !rsp_ta_err && rsp_rdata == 16'h0000)
      else $error("write response");
endmodule : mdmctl_master_asserts
bind mdmctl_master mdmctl_master_asserts #(.HALF_CYCLES(HALF_CYCLES)) mdmctl_master_asserts_inst (
   .ref_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_read, .cmd_no_pre, .rsp_valid,
   .rsp_rdata, .rsp_ta_err, .mdc, .mdio_o, .mdio_oe
);

// ===== verification/mdmctl_phy_model.sv
// Behavioural management-port device facing the controller
`timescale 1ns/10ps
module mdmctl_phy_model #(
   parameter logic [4:0] OWN_ADDR = 5'h05
) (
   input wire logic mdc,
   input wire logic host_o,
   input wire logic host_oe,
   output logic line
);
   logic [15:0] regs [32];
   logic [12:0] hdr;
   logic [17:0] sh;
   logic hit;
   logic dev_o = 1'b1;
   logic dev_oe = 1'b0;
   logic seen = 1'b0;
   int ones = 0;
   // Released line floats up through the weak pull-up
   assign line = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);
   initial begin
      foreach (regs[i]) regs[i] = 16'h0000;
      regs[mdmctl_pkg::BASIC_STATUS_REG] = 16'h0040;
      forever begin
         @(posedge mdc); // Clock only sampled here
         if (line !== 1'b0) begin
            ones++;
         end else if (ones >= mdmctl_pkg::PREAMBLE_BITS || (seen && ones > 0)) begin
            seen = 1'b1;
            ones = 0;
            for (int i = 12; i >= 0; i--) begin
               @(posedge mdc);
               hdr[i] = line;
            end
            hit = hdr[12] && hdr[9:5] == OWN_ADDR;
            if (hit && hdr[11:10] == mdmctl_pkg::OP_READ) begin
               sh = {2'b00, regs[hdr[4:0]]};
               repeat (2) @(negedge mdc);
               dev_oe = 1'b1;
               dev_o = 1'b0;
               for (int i = 15; i >= 0; i--) begin
                  @(negedge mdc);
                  dev_o = sh[i];
               end
               @(negedge mdc);
               dev_oe = 1'b0;
            end else begin
               repeat (18) begin
                  @(posedge mdc);
                  sh = {sh[16:0], line};
               end
               // Status stays read-only; a bad turnaround drops the write
               if (hit && hdr[11:10] == mdmctl_pkg::OP_WRITE && sh[17:16] == mdmctl_pkg::TA_WRITE
                     && hdr[4:0] != mdmctl_pkg::BASIC_STATUS_REG) begin
                  regs[hdr[4:0]] = sh[15:0];
               end
            end
         end else begin
            ones = 0;
         end
      end
   end
endmodule : mdmctl_phy_model

// ===== verification/mdmctl_master_tb.sv
// Self-checking bench for the management controller against a device model
`timescale 1ns/10ps
module mdmctl_master_tb;
   localparam int HALF = 4;
   localparam int FRAME = mdmctl_pkg::HDR_BITS + 2 + mdmctl_pkg::DATA_BITS + mdmctl_pkg::IDLE_BITS;
   localparam logic [4:0] PHY = 5'h05;
   localparam logic [4:0] STAT = mdmctl_pkg::BASIC_STATUS_REG;
   localparam logic [4:0] CTRL = mdmctl_pkg::MANAGEMENT_CONTROL_REG;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   logic [4:0] cmd_phy = 5'h00;
   logic [4:0] cmd_reg = 5'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic cmd_no_pre = 1'b0;
   logic cmd_ready;
   logic rsp_valid;
   logic [15:0] rsp_rdata;
   logic rsp_ta_err;
   logic mdc;
   logic line;
   logic mdio_o;
   logic mdio_oe;
   logic pre_done = 1'b0;
   logic [15:0] ref_regs [32];
   int err_total = 0;
   int n_tests = 0;
   int rises = 0;
   always #2 ref_clk = ~ref_clk;
   always @(posedge mdc) rises++;
   mdmctl_master #(.HALF_CYCLES(HALF)) mdmctl_master_inst (
      .ref_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_read, .cmd_phy, .cmd_reg, .cmd_wdata, .cmd_no_pre,
      .rsp_valid, .rsp_rdata, .rsp_ta_err, .mdc, .mdio_i(line), .mdio_o, .mdio_oe
   );
   mdmctl_phy_model #(.OWN_ADDR(PHY)) mdmctl_phy_model_inst (.mdc, .host_o(mdio_o), .host_oe(mdio_oe), .line);
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_cnt
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   // ----------------------------------------
   // One whole frame, predicted from the rules
   // ----------------------------------------
   task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
         input logic np);
      logic hit;
      logic [15:0] exp;
      int k;
      hit = (phy == PHY);
      // A read that nobody answers sees only the pull-up, so all ones
      exp = rd ? (hit ? ref_regs[rg] : 16'hffff) : 16'h0000;
      if (!rd && hit && rg != STAT) begin
         ref_regs[rg] = wd;
      end
      @(negedge ref_clk);
      // Present the command only while ready stands, so it is taken at the next edge
      while (cmd_ready !== 1'b1) begin
         @(negedge ref_clk);
      end
      {cmd_valid, cmd_read, cmd_phy, cmd_reg, cmd_wdata, cmd_no_pre} = {1'b1, rd, phy, rg, wd, np};
      rises = 0;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 2000) begin
         @(negedge ref_clk);
         k++;
      end
      chk_cnt(rises, ((np && pre_done) ? 0 : mdmctl_pkg::PREAMBLE_BITS) + FRAME);
      chk_val({15'h0000, rsp_valid}, 16'h0001);
      chk_val({15'h0000, rsp_ta_err}, {15'h0000, rd && !hit});
      chk_val(rsp_rdata, exp);
      pre_done = 1'b1;
   endtask : xfer
   initial begin
      logic [4:0] rp;
      void'($urandom(32'hc878_8e9d));
      foreach (ref_regs[i]) ref_regs[i] = 16'h0000;
      ref_regs[STAT] = 16'h0040;
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      xfer(1'b0, PHY, CTRL, 16'h0002, 1'b1);
      xfer(1'b1, PHY, STAT, 16'h0000, 1'b1);
      xfer(1'b0, PHY, STAT, 16'hffff, 1'b1);
      xfer(1'b1, PHY, STAT, 16'h0000, 1'b0);
      xfer(1'b1, PHY ^ 5'h01, CTRL, 16'h0000, 1'b1);
      xfer(1'b0, 5'h1f, CTRL, 16'h1234, 1'b1);
      xfer(1'b1, PHY, CTRL, 16'h0000, 1'b1);
      repeat (40) begin
         rp = $urandom_range(0, 5) ? PHY : 5'($urandom);
         xfer(1'($urandom), rp, 5'($urandom), 16'($urandom), 1'($urandom));
      end
      // Reset between frames must bring the full preamble back
      @(negedge ref_clk);
      rst_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      pre_done = 1'b0;
      xfer(1'b1, PHY, CTRL, 16'h0000, 1'b1);
      conclude();
   end
   initial begin
      #300000;
      err_total++;
      $display("[ERR] %0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
      conclude();
   end
endmodule : mdmctl_master_tb
